// ### hdl/isc_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE1: Minimum resistance codes run 0x20 to 0x3F, rising code means smaller limit.
// RULE2: Host derives watchdog code from lowest expected sensor frequency.
// RULE3: Timeout flagged when sensor runs slower than the watchdog code implies.
// RULE4: Watchdog period register resets to 0x45, read/write at 0x03.
// RULE5: Drive bits 4:3 pick amplitude 1V/2V/4V; code 11 reserved.
// RULE6: Drive config resets 0x1B; window codes 010..111; bits 7:5 zero.
// RULE7: Clock config bit 1 selects external clock or crystal reference.
// RULE8: Clock config bit 0 resets one and turns crystal drive off.
// RULE9: Upper threshold bytes at 0x06/0x07, both reset 0xFF.
// RULE10: Lower threshold bytes at 0x08/0x09, both reset 0x00.
// RULE11: Offsets 0x01..0x05 ignore writes while in active mode.
// RULE12: Host must write minimum resistance since its default is invalid.
// RULE13: Comparator bit one below lower threshold, zero above upper.
// RULE14: Timeout status follows the watchdog timeout detection.
// RULE15: Comparator holds its state between thresholds (hysteresis).
module isc_config_regs
    import isc_pkg::*;
(
    input  wire logic                       CLK,
    input  wire logic                       RESET_N,
    input  wire logic                       WR_EN,
    input  wire logic                       RD_EN,
    input  wire logic [isc_pkg::ADDR_W-1:0] ADDR,
    input  wire logic [isc_pkg::DATA_W-1:0] WDATA,
    input  wire logic                       ACTIVE_STATE_BIT,
    input  wire logic [15:0]                PROX_DATA,
    input  wire logic                       PROX_VALID,
    input  wire logic                       OSC_SLOW,
    output var  logic [isc_pkg::DATA_W-1:0] RDATA,
    output var  logic [7:0]                 RP_MIN_CODE,
    output var  logic [7:0]                 WDOG_CODE,
    output var  logic [1:0]                 AMPLITUDE_SEL,
    output var  logic [2:0]                 CONVERSION_WINDOW_SELECT,
    output var  logic                       CLK_SRC_CRYSTAL,
    output var  logic                       CRYSTAL_DRIVE_OFF,
    output var  logic                       RP_MIN_VALID,
    output var  logic                       COMPARATOR_STATUS,
    output var  logic                       OSC_TIMEOUT
);
    import isc_pkg::*;

    // Locked config check, used for write gating
    function automatic logic is_locked_cfg(input logic [7:0] a);
        is_locked_cfg = (a >= OFF_RP_MAX) && (a <= OFF_LAST_CFG);
    endfunction

    logic       we;
    logic [7:0] wd;
    logic [7:0] mem_r [NUM_REGS];
    logic [7:0] rdata_q;
    logic       act_s1_r, act_s2_r, osc_s1_r, osc_s2_r;
    logic       cmp_r, cmp_nxt, to_r, to_nxt;
    logic [15:0] uth, lth;
    logic       rd_pend_r;
    logic [7:0] rdata_nxt;

    // Write gating and field masking
    always_comb begin
        we = WR_EN && (ADDR < ADDR_W'(NUM_REGS)) && (ADDR != ZERO_BYTE);
        if (is_locked_cfg(ADDR) && act_s2_r) begin
            we = 1'b0; // RULE11
        end
        wd = WDATA;
        if (ADDR == OFF_DRIVE) begin
            wd = WDATA & DRIVE_MASK; // RULE6
        end
        if (ADDR == OFF_CLKSRC) begin
            wd = WDATA & CLKSRC_MASK; // RULE7 RULE8
        end
    end

    isc_regmem u_mem (
        .clk     (CLK),
        .reset_n (RESET_N),
        .we      (we),
        .waddr   (ADDR),
        .wdata   (wd),
        .raddr   (ADDR),
        .rdata_r (rdata_q),
        .mem_r   (mem_r)
    );

    // Threshold pairs
    assign uth = {mem_r[OFF_UTH_HI[3:0]], mem_r[OFF_UTH_LO[3:0]]}; // RULE9
    assign lth = {mem_r[OFF_LTH_HI[3:0]], mem_r[OFF_LTH_LO[3:0]]}; // RULE10

    // Read data path; the store's read register answers one edge after the strobe,
    // so the strobe is delayed by one flop to pick up the right byte
    always_comb begin
        rdata_nxt = RDATA;
        if (rd_pend_r) begin
            rdata_nxt = rdata_q;
        end
    end

    // Comparator hysteresis and timeout status next values
    always_comb begin
        cmp_nxt = cmp_r;
        if (PROX_VALID) begin
            if (PROX_DATA < lth) begin
                cmp_nxt = 1'b1; // RULE13 RULE15
            end else if (PROX_DATA > uth) begin
                cmp_nxt = 1'b0; // RULE13 RULE15
            end
        end
        to_nxt = osc_s2_r; // RULE3 RULE14
    end

    // Status and synchronisers
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            act_s1_r <= 1'b0;
            act_s2_r <= 1'b0;
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            cmp_r    <= 1'b0;
            to_r     <= 1'b0;
            rd_pend_r <= 1'b0;
        end else begin
            act_s1_r <= ACTIVE_STATE_BIT;
            act_s2_r <= act_s1_r;
            osc_s1_r <= OSC_SLOW;
            osc_s2_r <= osc_s1_r;
            cmp_r    <= cmp_nxt;
            to_r     <= to_nxt;
            rd_pend_r <= RD_EN;
        end
    end

    // Output flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            RDATA                    <= ZERO_BYTE;
            RP_MIN_CODE              <= RST_RP_MIN;
            WDOG_CODE                <= RST_WDOG; // RULE4
            AMPLITUDE_SEL            <= RST_DRIVE[AMP_LSB+1:AMP_LSB];
            CONVERSION_WINDOW_SELECT <= RST_DRIVE[2:0];
            CLK_SRC_CRYSTAL          <= RST_CLKSRC[CLK_SEL_BIT];
            CRYSTAL_DRIVE_OFF        <= RST_CLKSRC[XTAL_OFF_BIT];
            RP_MIN_VALID             <= 1'b0;
            COMPARATOR_STATUS        <= 1'b0;
            OSC_TIMEOUT              <= 1'b0;
        end else begin
            RDATA                    <= rdata_nxt;
            RP_MIN_CODE              <= mem_r[OFF_RP_MIN[3:0]];
            WDOG_CODE                <= mem_r[OFF_WDOG[3:0]]; // RULE4
            AMPLITUDE_SEL            <= mem_r[OFF_DRIVE[3:0]][AMP_LSB+1:AMP_LSB]; // RULE5
            CONVERSION_WINDOW_SELECT <= mem_r[OFF_DRIVE[3:0]][2:0]; // RULE6
            CLK_SRC_CRYSTAL          <= mem_r[OFF_CLKSRC[3:0]][CLK_SEL_BIT]; // RULE7
            CRYSTAL_DRIVE_OFF        <= mem_r[OFF_CLKSRC[3:0]][XTAL_OFF_BIT]; // RULE8
            RP_MIN_VALID             <= (mem_r[OFF_RP_MIN[3:0]] >= RP_MIN_LO) &&
                                        (mem_r[OFF_RP_MIN[3:0]] <= RP_MIN_HI); // RULE1 RULE12
            COMPARATOR_STATUS        <= cmp_r;
            OSC_TIMEOUT              <= to_r;
        end
    end

    // Checks
    locked_cfg_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE11
        (WR_EN && act_s2_r && ADDR == OFF_WDOG) |=> $stable(mem_r[OFF_WDOG[3:0]]))
        else $error("config written while active");
    wdog_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE4
        (WR_EN && !act_s2_r && ADDR == OFF_WDOG) |-> ##2 WDOG_CODE == $past(WDATA, 2))
        else $error("watchdog code not updated");
    drive_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE6
        mem_r[OFF_DRIVE[3:0]][7:5] == 3'h0)
        else $error("drive reserved bits set");
    clk_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE8
        (mem_r[OFF_CLKSRC[3:0]] & ~CLKSRC_MASK) == ZERO_BYTE)
        else $error("clock reserved bits set");
    cmp_low_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE13
        (PROX_VALID && PROX_DATA < lth) |-> ##2 COMPARATOR_STATUS)
        else $error("comparator not set below lower");
    cmp_high_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE13
        (PROX_VALID && PROX_DATA > uth && PROX_DATA >= lth) |-> ##2 !COMPARATOR_STATUS)
        else $error("comparator not cleared above upper");
    cmp_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE15
        (!PROX_VALID || (PROX_DATA >= lth && PROX_DATA <= uth)) |=> cmp_r == $past(cmp_r))
        else $error("comparator moved inside band");
    // Timeout must show once the slow level has crossed both sync stages, to_r and the output flop
    osc_follow_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE14
        OSC_SLOW [*5] |-> OSC_TIMEOUT)
        else $error("timeout not reported");
    // Bus side checks: reads answer with the stored byte, writes land a cycle later
    rd_data_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE4
        (RD_EN && !WR_EN && ADDR == OFF_WDOG) |-> ##2 RDATA == WDOG_CODE)
        else $error("read data does not match watchdog code");
    drive_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE6
        (WR_EN && !act_s2_r && ADDR == OFF_DRIVE) |=>
        mem_r[OFF_DRIVE[3:0]] == ($past(WDATA) & DRIVE_MASK))
        else $error("drive config write lost");
    uth_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE9
        (WR_EN && ADDR == OFF_UTH_HI) |=> mem_r[OFF_UTH_HI[3:0]] == $past(WDATA))
        else $error("upper threshold write lost");
    lth_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE10
        (WR_EN && ADDR == OFF_LTH_LO) |=> mem_r[OFF_LTH_LO[3:0]] == $past(WDATA))
        else $error("lower threshold write lost");
    // Field outputs track the store one edge behind, and the timeout clears once the sensor is no longer slow
    rp_range_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE1
        RP_MIN_VALID == ((RP_MIN_CODE >= RP_MIN_LO) && (RP_MIN_CODE <= RP_MIN_HI)))
        else $error("resistance code range flag wrong");
    amp_out_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE5
        AMPLITUDE_SEL == $past(mem_r[OFF_DRIVE[3:0]][AMP_LSB+1:AMP_LSB]))
        else $error("amplitude output stale");
    xtal_out_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE8
        CRYSTAL_DRIVE_OFF == $past(mem_r[OFF_CLKSRC[3:0]][XTAL_OFF_BIT]))
        else $error("crystal drive output stale");
    osc_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE14
        (!OSC_SLOW) [*5] |-> !OSC_TIMEOUT)
        else $error("timeout reported without slow sensor");

    // Main scenarios
    uth_write_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        WR_EN && ADDR == OFF_UTH_HI);
    locked_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        WR_EN && act_s2_r && ADDR == OFF_DRIVE);
    cmp_set_c: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(COMPARATOR_STATUS));
    rd_wdog_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        RD_EN && ADDR == OFF_WDOG);
    tmo_set_c: cover property (@(posedge CLK) disable iff (!RESET_N) $rose(OSC_TIMEOUT));
endmodule
`default_nettype wire

// ### hdl/isc_pkg.sv
package isc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int NUM_REGS = 10;
    // Register offsets
    localparam logic [7:0] OFF_RP_MAX   = 8'h01;
    localparam logic [7:0] OFF_RP_MIN   = 8'h02;
    localparam logic [7:0] OFF_WDOG     = 8'h03;
    localparam logic [7:0] OFF_DRIVE    = 8'h04;
    localparam logic [7:0] OFF_CLKSRC   = 8'h05;
    localparam logic [7:0] OFF_UTH_LO   = 8'h06;
    localparam logic [7:0] OFF_UTH_HI   = 8'h07;
    localparam logic [7:0] OFF_LTH_LO   = 8'h08;
    localparam logic [7:0] OFF_LTH_HI   = 8'h09;
    localparam logic [7:0] OFF_LAST_CFG = 8'h05;
    // Reset values
    localparam logic [7:0] RST_RP_MAX = 8'h0E;
    localparam logic [7:0] RST_RP_MIN = 8'h14;
    localparam logic [7:0] RST_WDOG   = 8'h45;
    localparam logic [7:0] RST_DRIVE  = 8'h1B;
    localparam logic [7:0] RST_CLKSRC = 8'h01;
    localparam logic [7:0] RST_UTH    = 8'hFF;
    localparam logic [7:0] RST_LTH    = 8'h00;
    // Field layout
    localparam logic [7:0] DRIVE_MASK   = 8'h1F;
    localparam logic [7:0] CLKSRC_MASK  = 8'h03;
    localparam int AMP_LSB = 3;
    localparam logic [1:0] AMP_RESERVED = 2'h3;
    localparam logic [2:0] WIN_MIN_CODE = 3'h2;
    localparam logic [7:0] RP_MIN_LO    = 8'h20;
    localparam logic [7:0] RP_MIN_HI    = 8'h3F;
    localparam int CLK_SEL_BIT = 1;
    localparam int XTAL_OFF_BIT = 0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage

// ### hdl/isc_regmem.sv
`timescale 1ns/100ps
`default_nettype none
// Small byte register store with registered read data
module isc_regmem
    import isc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    input  wire logic                       we,
    input  wire logic [isc_pkg::ADDR_W-1:0] waddr,
    input  wire logic [isc_pkg::DATA_W-1:0] wdata,
    input  wire logic [isc_pkg::ADDR_W-1:0] raddr,
    output var  logic [isc_pkg::DATA_W-1:0] rdata_r,
    output var  logic [isc_pkg::DATA_W-1:0] mem_r [isc_pkg::NUM_REGS]
);
    import isc_pkg::*;

    function automatic logic [7:0] rst_val(input int i);
        unique case (i)
            1: rst_val = RST_RP_MAX;
            2: rst_val = RST_RP_MIN;
            3: rst_val = RST_WDOG;
            4: rst_val = RST_DRIVE;
            5: rst_val = RST_CLKSRC;
            6, 7: rst_val = RST_UTH;
            default: rst_val = RST_LTH;
        endcase
    endfunction

    logic [7:0] mem_nxt [NUM_REGS];
    logic [7:0] rdata_nxt;

    // Next values of the store and the read port
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            mem_nxt[i] = (we && waddr == ADDR_W'(i)) ? wdata : mem_r[i];
        end
        rdata_nxt = (raddr < ADDR_W'(NUM_REGS)) ? mem_r[raddr[3:0]] : ZERO_BYTE;
    end

    // Registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_r[i] <= rst_val(i);
            end
            rdata_r <= ZERO_BYTE;
        end else begin
            mem_r   <= mem_nxt;
            rdata_r <= rdata_nxt;
        end
    end
endmodule
`default_nettype wire

// ### testbench/isc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side of the register port, one request per call
module isc_host_model
    import isc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic [isc_pkg::DATA_W-1:0] rdata,
    output var  logic                       wr_en,
    output var  logic                       rd_en,
    output var  logic [isc_pkg::ADDR_W-1:0] addr,
    output var  logic [isc_pkg::DATA_W-1:0] wdata
);
    import isc_pkg::*;
    // Idle bus after time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // Watchdog code from the lowest sensor frequency, rounded
    function automatic logic [7:0] wdog_code(input real f_hz);
        return 8'($rtoi(68.94 * $log10(f_hz / 2500.0) + 0.5));
    endfunction
    // Write held over one sampling edge, bus inverted once released, then a quiet edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        addr = ~a;
        wdata = ~d;
        @(posedge clk);
        #1;
    endtask
    // Read data settles one edge after the taking edge, sampled after the next edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        repeat (2) @(posedge clk);
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import isc_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, act = 1'b0, pv = 1'b0, slow = 1'b0;
    logic [15:0] prox = 16'h0000;
    logic wr_en, rd_en, xsel, xoff, rp_ok, cmp, tmo;
    logic [7:0] addr, wdata, rdata, rp_code, wd_code, v;
    logic [1:0] amp;
    logic [2:0] win;
    int bad_count = 0, check_count = 0, cycles = 0;
    isc_host_model i_isc_host_model (.clk(clk), .rdata(rdata), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata));
    isc_config_regs i_isc_config_regs (.CLK(clk), .RESET_N(reset_n), .WR_EN(wr_en),
        .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .ACTIVE_STATE_BIT(act),
        .PROX_DATA(prox), .PROX_VALID(pv), .OSC_SLOW(slow), .RDATA(rdata),
        .RP_MIN_CODE(rp_code), .WDOG_CODE(wd_code), .AMPLITUDE_SEL(amp),
        .CONVERSION_WINDOW_SELECT(win), .CLK_SRC_CRYSTAL(xsel), .CRYSTAL_DRIVE_OFF(xoff),
        .RP_MIN_VALID(rp_ok), .COMPARATOR_STATUS(cmp), .OSC_TIMEOUT(tmo));
    // Clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    // Reset contents, plus unmapped offset reading zero
    task automatic t_reset();
        logic [7:0] e [10] = '{8'h00, 8'h0E, 8'h14, 8'h45, 8'h1B, 8'h01,
                               8'hFF, 8'hFF, 8'h00, 8'h00};
        chk({wd_code, amp, win, xoff}, {8'h45, 5'h1B, 1'b1});
        for (int a = 1; a < 10; a++) begin
            i_isc_host_model.rd(8'(a), v);
            chk(v, e[a]);
        end
        i_isc_host_model.rd(8'h0A, v);
        chk(v, 8'h00);
    endtask
    // Every legal amplitude and window code, then clock source bits
    task automatic t_fields();
        for (int a = 0; a < 3; a++) begin
            for (int w = 2; w < 8; w++) begin
                i_isc_host_model.wr(OFF_DRIVE, {3'h0, 2'(a), 3'(w)});
                settle();
                chk({amp, win}, {2'(a), 3'(w)});
            end
        end
        i_isc_host_model.wr(OFF_CLKSRC, 8'h02);
        i_isc_host_model.rd(OFF_CLKSRC, v);
        chk({v, xsel, xoff}, {8'h02, 2'b10});
        i_isc_host_model.wr(OFF_CLKSRC, 8'h01);
        settle();
        chk({xsel, xoff}, 2'b01);
    endtask
    // Minimum resistance code range edges
    task automatic t_rpmin();
        logic [7:0] c [4] = '{8'h1F, 8'h20, 8'h3F, 8'h40};
        logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            i_isc_host_model.wr(OFF_RP_MIN, c[i]);
            settle();
            chk({rp_code, rp_ok}, {c[i], e[i]});
        end
    endtask
    // Watchdog code for a 1 MHz sensor, then a locked write in active mode
    task automatic t_lock();
        i_isc_host_model.wr(OFF_WDOG, i_isc_host_model.wdog_code(1.0e6));
        settle();
        chk(wd_code, 8'hB3);
        act = 1'b1;
        settle();
        settle();
        i_isc_host_model.wr(OFF_WDOG, 8'h11);
        i_isc_host_model.wr(OFF_UTH_LO, 8'h00);
        i_isc_host_model.wr(OFF_UTH_HI, 8'h01);
        i_isc_host_model.wr(OFF_LTH_LO, 8'h80);
        i_isc_host_model.rd(OFF_WDOG, v);
        chk(v, 8'hB3);
        i_isc_host_model.rd(OFF_UTH_HI, v);
        chk(v, 8'h01);
        act = 1'b0;
    endtask
    // Hysteresis between 0x0080 and 0x0100, then the oscillation timeout
    task automatic t_cmp();
        logic [15:0] p [4] = '{16'h0050, 16'h00C0, 16'h0200, 16'h00C0};
        logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++) begin
            prox = p[i];
            pv = 1'b1;
            @(posedge clk);
            #1;
            pv = 1'b0;
            settle();
            chk(cmp, e[i]);
        end
        slow = 1'b1;
        settle();
        settle();
        settle();
        chk(tmo, 1'b1);
        slow = 1'b0;
        settle();
        settle();
        chk(tmo, 1'b0);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_fields();
        t_rpmin();
        t_lock();
        t_cmp();
        print_verdict();
    end
endmodule
`default_nettype wire
